// File: src/spss_consts.svh
`ifndef SPSS_CONSTS_SVH
`define SPSS_CONSTS_SVH

// ****************************************************
// register offsets (byte addresses)
// ****************************************************
`define SPSS_ADDR_W 12
`define SPSS_OFS_CTRL 12'h000
`define SPSS_OFS_CFG 12'h004
`define SPSS_OFS_STAT 12'h008

// ****************************************************
// control register fields
// ****************************************************
`define SPSS_SLPEN_BIT 0
`define SPSS_SLPTYP_LSB 1
`define SPSS_SLPTYP_MSB 3
`define SPSS_SLPTYP_RST 3'h0
`define SPSS_SLPTYP_S3 3'h3
`define SPSS_SLPTYP_S4 3'h4
`define SPSS_SLPTYP_S5 3'h5

// ****************************************************
// configuration register fields
// ****************************************************
`define SPSS_POL_LSB 0
`define SPSS_POL_MSB 1
`define SPSS_POL_RST 2'h0
`define SPSS_POL_REBOOT 2'h0
`define SPSS_POL_STAYOFF 2'h1
`define SPSS_POL_RESTORE 2'h2
`define SPSS_WAKE_LSB 8
`define SPSS_WAKE_MSB 11
`define SPSS_WAKE_RST 4'h0
`define SPSS_WAKE_KEEP_MASK 4'h3

// ****************************************************
// status register fields
// ****************************************************
`define SPSS_ST_STATE_LSB 0
`define SPSS_ST_CSTATE_LSB 6
`define SPSS_ST_GFXD3_BIT 8
`define SPSS_ST_WASS4_BIT 9
`define SPSS_ST_RAILS_LSB 16

`endif

// File: src/spss_pkg.sv
package spss_pkg;

   // ****************************************************
   // system states, one-hot
   // ****************************************************
   typedef enum logic [5:0]
   {
      ST_G3 = 6'h01,
      ST_C0 = 6'h02,
      ST_CX = 6'h04,
      ST_S3 = 6'h08,
      ST_S4 = 6'h10,
      ST_S5 = 6'h20
   } spss_state_e;

   // processor-chosen idle level
   typedef enum logic [1:0]
   {
      CS_C1 = 2'h0,
      CS_C1E = 2'h1,
      CS_C6 = 2'h2,
      CS_C7 = 2'h3
   } spss_cstate_e;

   // ****************************************************
   // platform rail enables
   // ****************************************************
   typedef struct packed
   {
      logic rtcBackup;
      logic alwaysOn;
      logic memoryIo;
      logic storageIo;
      logic switched1v15;
      logic uncore;
      logic graphics;
      logic core;
   } spss_rails_s;

endpackage : spss_pkg

// File: src/spss_sync.sv
`timescale 1ns/10ps

module spss_sync #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [W-1:0] async,
   output logic [W-1:0] synced
);

   // ****************************************************
   // two-stage synchroniser per bit
   // ****************************************************
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic meta_r;
         logic sync_r;
         always_ff @(posedge mclk)
         begin
            if (srst)
            begin
               meta_r <= 1'b0;
               sync_r <= 1'b0;
            end
            else if (ce)
            begin
               meta_r <= async[i];
               sync_r <= meta_r;
            end
         end
         assign synced[i] = sync_r;
      end
   endgenerate

endmodule : spss_sync

// File: src/spss_top.sv
`timescale 1ns/10ps
`include "spss_consts.svh"

// Function
// RQ1 - in full-on, an idle request moves the system to working idle
// RQ2 - in full-on, sleep enable moves to the state named by sleep type
// RQ3 - in working idle, snoop, MSI, interrupt or timer return to full-on
// RQ4 - from suspend-to-disk or soft-off, an enabled wake returns to full-on
// RQ5 - resume power loss, or mains loss in full-on, forces mechanical-off; in full-on only mains loss is checked
// RQ6 - power return from mechanical-off: reboot, stay soft-off, or restore S4
// RQ7 - some wake enables survive mechanical-off and stay enabled afterwards
// RQ8 - suspend-to-disk and soft-off behave identically, only wake logic powered
// RQ9 - leaving soft-off requests a full boot; no context kept
// RQ10 - processor picks idle level; graphics D3 and display off for deep levels
// RQ11 - rail enables per state: S0 all, S3 partial, S4/S5 less, G3 rtc only
// RQ12 - transitions go straight to final state; intermediates are tolerated
// RQ13 - power-button override forces soft-off from full-on, idle or S4
module spss_top (
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic idleReq,
   input wire spss_pkg::spss_cstate_e idleLevel,
   input wire logic breakSnoop,
   input wire logic breakMsi,
   input wire logic breakIntr,
   input wire logic alwaysOnTimerExpired,
   input wire logic resumePowerOk,
   input wire logic mainPowerOk,
   input wire logic powerButton,
   input wire logic powerButtonOverride,
   input wire logic [3:0] wakeEvent,
   output spss_pkg::spss_state_e sysState,
   output spss_pkg::spss_rails_s railEnable,
   output logic graphicsD3,
   output logic displayOff,
   output logic coldBootReq
);
   import spss_pkg::*;

   // ****************************************************
   // pin synchronisers
   // ****************************************************
   logic [7:0] pinSync;
   logic resumeOkS;
   logic mainOkS;
   logic btnS;
   logic overrideS;
   logic [3:0] wakeS;

   spss_sync #(.W(8)) u_sync (
      .mclk(mclk),
      .srst(srst),
      .ce(ce),
      .async({wakeEvent, powerButtonOverride, powerButton, mainPowerOk, resumePowerOk}),
      .synced(pinSync)
   );

   assign resumeOkS = pinSync[0];
   assign mainOkS = pinSync[1];
   assign btnS = pinSync[2];
   assign overrideS = pinSync[3];
   assign wakeS = pinSync[7:4];

   // ****************************************************
   // state registers
   // ****************************************************
   spss_state_e state_r;
   spss_state_e state_nxt;
   spss_cstate_e cState_r;
   logic wasS4_r;
   logic [2:0] sleepType_r;
   logic [1:0] policy_r;
   logic [3:0] wakeEn_r;
   logic [3:0] wakeEn_nxt;
   spss_rails_s rails_r;
   spss_rails_s rails_nxt;
   logic gfxD3_r;
   logic dispOff_r;
   logic coldBoot_r;
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic hresp_r;
   logic wrPend_r;
   logic [`SPSS_ADDR_W-1:0] wrAddr_r;

   // ****************************************************
   // bus decode
   // ****************************************************
   wire addrPhase = hsel && htrans[1] && hready;
   wire [`SPSS_ADDR_W-1:0] addrLow = haddr[`SPSS_ADDR_W-1:0];
   wire wrCtrl = wrPend_r && (wrAddr_r == `SPSS_OFS_CTRL);
   wire wrCfg = wrPend_r && (wrAddr_r == `SPSS_OFS_CFG);
   wire [2:0] wrSleepType = hwdata[`SPSS_SLPTYP_MSB:`SPSS_SLPTYP_LSB];
   wire sleepGo = wrCtrl && hwdata[`SPSS_SLPEN_BIT];
   wire [31:0] ctrlWord = {28'h0, sleepType_r, 1'b0};
   wire [31:0] cfgWord = {20'h0, wakeEn_r, 6'h0, policy_r};
   wire [31:0] statWord = {8'h0, rails_r, 6'h0, wasS4_r, gfxD3_r, cState_r, state_r};
   wire [31:0] rdMux = (addrLow == `SPSS_OFS_CTRL) ? ctrlWord :
                       (addrLow == `SPSS_OFS_CFG) ? cfgWord :
                       (addrLow == `SPSS_OFS_STAT) ? statWord : 32'h0;

   // ****************************************************
   // transition triggers
   // ****************************************************
   wire breakHit = breakSnoop || breakMsi || breakIntr || alwaysOnTimerExpired; // [RQ3]
   wire wakeHit = btnS || (|(wakeS & wakeEn_r)); // [RQ4]
   wire powerBack = resumeOkS && mainOkS;
   wire deepIdle = (cState_r == CS_C6) || (cState_r == CS_C7);
   wire sleepValid = (wrSleepType == `SPSS_SLPTYP_S3) || (wrSleepType == `SPSS_SLPTYP_S4) ||
                     (wrSleepType == `SPSS_SLPTYP_S5);

   // ****************************************************
   // next-state logic; power loss first, then override
   // ****************************************************
   always_comb
   begin
      state_nxt = state_r;
      // each trigger lands directly in its final state [RQ12]
      case (state_r)
         ST_C0:
         begin
            if (!mainOkS)
               state_nxt = ST_G3; // [RQ5]
            else if (overrideS)
               state_nxt = ST_S5; // [RQ13]
            else if (sleepGo && sleepValid)
            begin
               if (wrSleepType == `SPSS_SLPTYP_S3)
                  state_nxt = ST_S3; // [RQ2]
               else if (wrSleepType == `SPSS_SLPTYP_S4)
                  state_nxt = ST_S4; // [RQ2]
               else
                  state_nxt = ST_S5; // [RQ2]
            end
            else if (idleReq)
               state_nxt = ST_CX; // [RQ1]
         end
         ST_CX:
         begin
            if (!resumeOkS)
               state_nxt = ST_G3; // [RQ5]
            else if (overrideS)
               state_nxt = ST_S5; // [RQ13]
            else if (breakHit)
               state_nxt = ST_C0; // [RQ3]
         end
         ST_S3:
         begin
            if (!resumeOkS)
               state_nxt = ST_G3;
            else if (overrideS)
               state_nxt = ST_S5;
            else if (wakeHit)
               state_nxt = ST_C0;
         end
         ST_S4, ST_S5:
         begin
            // both states share one handling path [RQ8]
            if (!resumeOkS)
               state_nxt = ST_G3; // [RQ5]
            else if (overrideS)
               state_nxt = ST_S5; // [RQ13]
            else if (wakeHit)
               state_nxt = ST_C0; // [RQ4]
         end
         ST_G3:
         begin
            if (powerBack)
            begin
               if (policy_r == `SPSS_POL_REBOOT)
                  state_nxt = ST_C0; // [RQ6]
               else if ((policy_r == `SPSS_POL_RESTORE) && wasS4_r)
                  state_nxt = ST_S4; // [RQ6]
               else
                  state_nxt = ST_S5; // [RQ6]
            end
         end
         default:
            state_nxt = ST_G3;
      endcase
   end

   // ****************************************************
   // rail and graphics decode
   // ****************************************************
   always_comb
   begin
      rails_nxt = '1; // [RQ11]
      case (state_nxt)
         ST_S3:
         begin
            rails_nxt.core = 1'b0; // [RQ11]
            rails_nxt.graphics = 1'b0;
            rails_nxt.switched1v15 = 1'b0;
            rails_nxt.storageIo = 1'b0;
         end
         ST_S4, ST_S5:
         begin
            rails_nxt = '0; // [RQ11] [RQ8]
            rails_nxt.uncore = 1'b1;
            rails_nxt.alwaysOn = 1'b1;
            rails_nxt.rtcBackup = 1'b1;
         end
         ST_G3:
         begin
            rails_nxt = '0; // [RQ11]
            rails_nxt.rtcBackup = 1'b1;
         end
         default:
            rails_nxt = '1;
      endcase
   end

   // retained enables survive mechanical-off, the rest drop [RQ7]
   always_comb
   begin
      wakeEn_nxt = wakeEn_r;
      if (wrCfg)
         wakeEn_nxt = hwdata[`SPSS_WAKE_MSB:`SPSS_WAKE_LSB];
      else if ((state_nxt == ST_G3) && (state_r != ST_G3))
         wakeEn_nxt = wakeEn_r & `SPSS_WAKE_KEEP_MASK; // [RQ7]
   end

   wire enterC0 = (state_nxt == ST_C0) && (state_r != ST_C0) && (state_r != ST_CX);
   wire gfxDeepNxt = (state_nxt == ST_CX) &&
                     (((state_r == ST_C0) && ((idleLevel == CS_C6) || (idleLevel == CS_C7))) ||
                      ((state_r == ST_CX) && deepIdle));

   // ****************************************************
   // sequencer registers
   // ****************************************************
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         state_r <= ST_G3;
         cState_r <= CS_C1;
         wasS4_r <= 1'b0;
         rails_r <= '0;
         gfxD3_r <= 1'b1;
         dispOff_r <= 1'b1;
         coldBoot_r <= 1'b0;
      end
      else if (ce)
      begin
         state_r <= state_nxt;
         if ((state_r == ST_C0) && idleReq)
            cState_r <= idleLevel; // [RQ10]
         if (state_nxt == ST_S4)
            wasS4_r <= 1'b1;
         else if (state_nxt == ST_C0)
            wasS4_r <= 1'b0;
         rails_r <= rails_nxt;
         gfxD3_r <= gfxDeepNxt || !((state_nxt == ST_C0) || (state_nxt == ST_CX)); // [RQ10]
         dispOff_r <= gfxDeepNxt || !((state_nxt == ST_C0) || (state_nxt == ST_CX));
         coldBoot_r <= enterC0 && (state_r != ST_S3); // [RQ9]
      end
   end

   // ****************************************************
   // register file and bus slave
   // ****************************************************
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         sleepType_r <= `SPSS_SLPTYP_RST;
         policy_r <= `SPSS_POL_RST;
         wakeEn_r <= `SPSS_WAKE_RST;
         hrdata_r <= 32'h0;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
         wrPend_r <= 1'b0;
         wrAddr_r <= '0;
      end
      else if (ce)
      begin
         if (wrCtrl)
            sleepType_r <= wrSleepType;
         if (wrCfg)
            policy_r <= hwdata[`SPSS_POL_MSB:`SPSS_POL_LSB];
         wakeEn_r <= wakeEn_nxt;
         if (addrPhase && !hwrite)
            hrdata_r <= rdMux;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
         wrPend_r <= addrPhase && hwrite;
         if (addrPhase)
            wrAddr_r <= addrLow;
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = hresp_r;
   assign sysState = state_r;
   assign railEnable = rails_r;
   assign graphicsD3 = gfxD3_r;
   assign displayOff = dispOff_r;
   assign coldBootReq = coldBoot_r;

   // ****************************************************
   // assertions
   // ****************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst || !ce);

   property p_idle;
      (state_r == ST_C0) && idleReq && mainOkS && !overrideS && !sleepGo |=> state_r == ST_CX;
   endproperty
   a_idle: assert property (p_idle) else $error("idle request not taken"); // [RQ1]

   property p_sleep;
      (state_r == ST_C0) && mainOkS && !overrideS && sleepGo &&
      (wrSleepType == `SPSS_SLPTYP_S4) |=> state_r == ST_S4 ##1 !rails_r.memoryIo;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep entry wrong"); // [RQ2]

   property p_break;
      (state_r == ST_CX) && resumeOkS && !overrideS && breakHit |=> state_r == ST_C0;
   endproperty
   a_break: assert property (p_break) else $error("break event lost"); // [RQ3]

   property p_wake;
      ((state_r == ST_S4) || (state_r == ST_S5)) && resumeOkS && !overrideS && wakeHit
      |=> (state_r == ST_C0) && coldBootReq;
   endproperty
   a_wake: assert property (p_wake) else $error("wake not honoured"); // [RQ4]

   property p_fail;
      (state_r != ST_G3) && (state_r != ST_C0) && !resumeOkS |=> state_r == ST_G3 ##1
      (railEnable == spss_rails_s'(8'h80));
   endproperty
   a_fail: assert property (p_fail) else $error("power loss not handled"); // [RQ5]

   property p_reboot;
      (state_r == ST_G3) && powerBack && (policy_r == `SPSS_POL_REBOOT) |=> state_r == ST_C0;
   endproperty
   a_reboot: assert property (p_reboot) else $error("reboot path wrong"); // [RQ6]

   property p_s3rails;
      state_nxt == ST_S3 |=> !railEnable.core && railEnable.memoryIo && railEnable.uncore;
   endproperty
   a_s3rails: assert property (p_s3rails) else $error("S3 rails wrong"); // [RQ11]

   property p_override;
      (state_r == ST_C0) && mainOkS && overrideS |=> state_r == ST_S5;
   endproperty
   a_override: assert property (p_override) else $error("override ignored"); // [RQ13]

   property p_gfx;
      (state_r == ST_CX) && deepIdle && $stable(state_r) |-> graphicsD3 && displayOff;
   endproperty
   a_gfx: assert property (p_gfx) else $error("graphics not in D3"); // [RQ10]

   c_idle: cover property ((state_r == ST_C0) ##1 (state_r == ST_CX) ##[1:20] (state_r == ST_C0));
   c_s3: cover property ((state_r == ST_C0) ##1 (state_r == ST_S3));
   c_boot: cover property ((state_r == ST_G3) ##1 (state_r == ST_C0));
   c_s5wake: cover property ((state_r == ST_S5) ##1 (state_r == ST_C0));

endmodule : spss_top

// File: verif/spss_platform_model.sv
`timescale 1ns/10ps
// ****************************************************
// platform supplies and power button
// ****************************************************
module spss_platform_model (
   input wire logic mclk,
   output logic resumePowerOk,
   output logic mainPowerOk,
   output logic powerButton,
   output logic powerButtonOverride,
   output logic [3:0] wakeEvent
);
   initial
   begin
      resumePowerOk = 1'b0;
      mainPowerOk = 1'b0;
      {powerButtonOverride, powerButton, wakeEvent} = 6'h00;
   end
   // supply good levels
   task setPower(input logic mains, input logic resume);
      @(posedge mclk);
      mainPowerOk <= mains;
      resumePowerOk <= resume;
   endtask : setPower
   // override, button, wakes held 4 cycles for the synchroniser
   task pulse(input logic [5:0] pins);
      @(posedge mclk);
      {powerButtonOverride, powerButton, wakeEvent} <= pins;
      repeat (4) @(posedge mclk);
      {powerButtonOverride, powerButton, wakeEvent} <= 6'h00;
   endtask : pulse
endmodule : spss_platform_model

// File: verif/test_system_power_state_sequencer.sv
`timescale 1ns/10ps
`include "spss_consts.svh"
// ****************************************************
// bench for the power state sequencer
// ****************************************************
module test_system_power_state_sequencer;
   import spss_pkg::*;
   localparam logic [31:0] ACTRL = {20'h0, `SPSS_OFS_CTRL};
   localparam logic [31:0] ACFG = {20'h0, `SPSS_OFS_CFG};
   logic mclk = 1'b0;
   logic srst;
   logic ce;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic idleReq;
   spss_cstate_e idleLevel;
   logic [3:0] brk;
   logic resumePowerOk, mainPowerOk, powerButton, powerButtonOverride;
   logic [3:0] wakeEvent;
   spss_state_e sysState;
   spss_rails_s railEnable;
   logic graphicsD3, displayOff, coldBootReq;
   int errors = 0;
   int tests_run = 0;
   int boots = 0;
   logic [31:0] rd;

   always #12.5 mclk = ~mclk;
   always @(posedge coldBootReq) boots <= boots + 1;

   spss_top spss_top_i (
      .mclk(mclk), .srst(srst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .idleReq(idleReq),
      .idleLevel(idleLevel), .breakSnoop(brk[3]), .breakMsi(brk[2]), .breakIntr(brk[1]),
      .alwaysOnTimerExpired(brk[0]), .resumePowerOk(resumePowerOk),
      .mainPowerOk(mainPowerOk), .powerButton(powerButton),
      .powerButtonOverride(powerButtonOverride), .wakeEvent(wakeEvent),
      .sysState(sysState), .railEnable(railEnable), .graphicsD3(graphicsD3),
      .displayOff(displayOff), .coldBootReq(coldBootReq)
   );
   spss_platform_model spss_platform_model_i (
      .mclk(mclk), .resumePowerOk(resumePowerOk), .mainPowerOk(mainPowerOk),
      .powerButton(powerButton), .powerButtonOverride(powerButtonOverride),
      .wakeEvent(wakeEvent)
   );

   // ****************************************************
   // helpers
   // ****************************************************
   task summarize;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         errors++;
      end
   endtask : chk
   task waitReady;
      @(posedge mclk);
      while (hreadyout !== 1'b1)
         @(posedge mclk);
   endtask : waitReady
   // single word transfer, read data left in rd
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      waitReady();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      waitReady();
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask : ahb
   task waitState(input spss_state_e exp);
      int n;
      n = 0;
      @(negedge mclk);
      while (sysState !== exp && n < 40)
      begin
         @(negedge mclk);
         n++;
      end
      chk({26'h0, sysState}, {26'h0, exp});
   endtask : waitState
   task rails(input logic [7:0] exp);
      chk({24'h0, railEnable}, {24'h0, exp});
   endtask : rails
   task idleGo(input spss_cstate_e lvl);
      @(posedge mclk);
      idleLevel <= lvl;
      idleReq <= 1'b1;
      @(posedge mclk);
      idleReq <= 1'b0;
   endtask : idleGo
   task brkGo(input logic [3:0] b);
      @(posedge mclk);
      brk <= b;
      @(posedge mclk);
      brk <= 4'h0;
   endtask : brkGo

   // ****************************************************
   // scenarios
   // ****************************************************
   task tPowerUp;
      repeat (3) @(negedge mclk);
      chk({26'h0, sysState}, {26'h0, ST_G3});
      rails(8'h80);
      chk({30'h0, graphicsD3, displayOff}, 32'h3);
      ahb(1'b0, 32'h10, 32'h0);
      chk(rd, 32'h0);
      spss_platform_model_i.setPower(1'b1, 1'b1);
      waitState(ST_C0);
      rails(8'hff);
      chk(boots, 1);
   endtask : tPowerUp
   task tIdle;
      for (int i = 0; i < 4; i++)
      begin
         idleGo(spss_cstate_e'(i));
         waitState(ST_CX);
         chk({30'h0, graphicsD3, displayOff}, (i >= 2) ? 32'h3 : 32'h0);
         brkGo(4'h8 >> i);
         waitState(ST_C0);
      end
      idleGo(CS_C1);
      waitState(ST_CX);
      ahb(1'b1, ACTRL, 32'hb);
      repeat (4) @(negedge mclk);
      chk({26'h0, sysState}, {26'h0, ST_CX});
      brkGo(4'h2);
      waitState(ST_C0);
      @(posedge mclk);
      ce <= 1'b0;
      idleGo(CS_C6);
      @(posedge mclk);
      ce <= 1'b1;
      repeat (4) @(negedge mclk);
      chk({26'h0, sysState}, {26'h0, ST_C0});
   endtask : tIdle
   task tSleep;
      ahb(1'b1, ACTRL, 32'h7);
      waitState(ST_S3);
      rails(8'he4);
      spss_platform_model_i.pulse(6'h10);
      waitState(ST_C0);
      ahb(1'b1, ACFG, 32'h100);
      ahb(1'b1, ACTRL, 32'h9);
      waitState(ST_S4);
      rails(8'hc4);
      spss_platform_model_i.pulse(6'h02);
      repeat (10) @(negedge mclk);
      chk({26'h0, sysState}, {26'h0, ST_S4});
      spss_platform_model_i.pulse(6'h01);
      waitState(ST_C0);
      chk(boots, 2);
      ahb(1'b1, ACTRL, 32'hb);
      waitState(ST_S5);
      rails(8'hc4);
      spss_platform_model_i.pulse(6'h10);
      waitState(ST_C0);
      chk(boots, 3);
   endtask : tSleep
   task tOverride;
      spss_platform_model_i.pulse(6'h20);
      waitState(ST_S5);
      spss_platform_model_i.pulse(6'h10);
      waitState(ST_C0);
      idleGo(CS_C6);
      waitState(ST_CX);
      spss_platform_model_i.pulse(6'h20);
      waitState(ST_S5);
      spss_platform_model_i.pulse(6'h10);
      waitState(ST_C0);
      ahb(1'b1, ACTRL, 32'h9);
      waitState(ST_S4);
      spss_platform_model_i.pulse(6'h20);
      waitState(ST_S5);
      spss_platform_model_i.pulse(6'h10);
      waitState(ST_C0);
      chk(boots, 6);
   endtask : tOverride
   task tPowerFail;
      ahb(1'b1, ACFG, 32'hf01);
      spss_platform_model_i.setPower(1'b0, 1'b1);
      waitState(ST_G3);
      rails(8'h80);
      spss_platform_model_i.setPower(1'b1, 1'b1);
      waitState(ST_S5);
      ahb(1'b0, ACFG, 32'h0);
      chk(rd, 32'h301);
      spss_platform_model_i.pulse(6'h01);
      waitState(ST_C0);
      ahb(1'b1, ACFG, 32'h2);
      ahb(1'b1, ACTRL, 32'h9);
      waitState(ST_S4);
      spss_platform_model_i.setPower(1'b1, 1'b0);
      waitState(ST_G3);
      spss_platform_model_i.setPower(1'b1, 1'b1);
      waitState(ST_S4);
   endtask : tPowerFail

   // ****************************************************
   // main sequence and watchdog
   // ****************************************************
   initial
   begin
      srst = 1'b1;
      ce = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      idleReq = 1'b0;
      idleLevel = CS_C1;
      brk = 4'h0;
      repeat (6) @(posedge mclk);
      srst <= 1'b0;
      tPowerUp();
      tIdle();
      tSleep();
      tOverride();
      tPowerFail();
      summarize();
   end
   initial
   begin
      repeat (20000) @(posedge mclk);
      errors++;
      summarize();
   end
endmodule : test_system_power_state_sequencer
